// >>> core/cpsr_core.sv
// cnc program store, start and stored reference-approach interpreter
// assumes avalon-mm host, rx bytes written to rxdata, external pins async
//
// Notes on behaviour
// - in store mode each reference line within the axis configuration goes to program memory while it has room, not run
// - valid stored program starts on the external start input
// - save command rejected with error when memory holds any program
// - transfer error marks program invalid until erased and reloaded
// - save command is '@', device number, 'i', carriage return
// - after save accepted only storable commands until end or error
// - save command acknowledged to host
// - save accepted only when initialised and no motion running
// - reference command is '7', one axis mask digit, carriage return
// - mask weights 1 X, 2 Y, 4 Z, 8 A
// - selected axes homed in order Z, Y, X, A
// - after homing the next stored command is fetched
// - axis outside configuration rejected with error code 3
// - reference command drops 3D mode back to 2.5D
// - missing home switch keeps driving; stop input aborts homing
`timescale 1ns/100ps
`default_nettype none
module cpsr_core
  import cpsr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        start_in,
  input  wire logic        stop_in,
  input  wire logic [3:0]  home_sw,
  output logic [3:0]       home_drive,
  output logic             mode_3d,
  output logic             prog_running
);
  logic [7:0]  mem [PROG_DEPTH];
  logic [PROG_AW-1:0] wr_ptr;
  logic [PROG_AW-1:0] rd_ptr;
  logic        prog_valid;
  logic        prog_any;
  cpsr_state_t state;
  logic [31:0] ctrl;
  cpsr_resp_t  resp;
  logic [7:0]  line [LINE_MAX];
  logic [4:0]  line_len;
  logic [3:0]  home_mask;
  logic [1:0]  start_s;
  logic [1:0]  stop_s;
  logic [3:0]  home_s1;
  logic [3:0]  home_s2;
  logic        start_q;
  logic        acc;
  logic        rx_wr;
  logic        line_done;
  logic [3:0]  mask_val;
  logic [3:0]  axcfg;
  logic [3:0]  cur_axis;
  logic [3:0]  next_mask;
  logic        is_save;
  logic        is_ref;
  logic        is_end;
  logic        is_erase;

  // single-cycle wait on every access gives one registered answer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) acc <= 1'b0;
    else acc <= (avs_read | avs_write) & ~acc;
  end
  assign rx_wr = avs_write & acc & (avs_address == OFS_RXDATA);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= ~((avs_read | avs_write) & ~acc);
  end

  // pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_s <= 2'b00;
      stop_s  <= 2'b00;
      start_q <= 1'b0;
    end else begin
      start_s <= {start_s[0], start_in};
      stop_s  <= {stop_s[0], stop_in};
      start_q <= start_s[1];
    end
  end

  // home switch synchronisers, one pair per axis
  for (genvar gi = 0; gi < 4; gi++) begin : g_home_sync
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        home_s1[gi] <= 1'b0;
        home_s2[gi] <= 1'b0;
      end else begin
        home_s1[gi] <= home_sw[gi];
        home_s2[gi] <= home_s1[gi];
      end
    end
  end

  // line assembly and parse
  assign line_done = rx_wr && (avs_writedata[7:0] == CH_CR);
  assign is_save = (line_len == 5'd3) && (line[0] == CH_AT)
    && (line[1] >= CH_ZERO) && (line[1] <= CH_NINE)
    && (line[2] == CH_I);
  assign is_erase = (line_len == 5'd3) && (line[0] == CH_AT)
    && (line[2] == CH_K);
  assign is_ref = (line_len == 5'd2) && (line[0] == CH_SEVEN)
    && (line[1] >= CH_ZERO) && (line[1] <= CH_NINE);
  assign is_end = (line_len == 5'd1) && (line[0] == CH_ENDF);
  assign mask_val = line[1][3:0] - CH_ZERO[3:0];
  assign axcfg = ctrl[CTRL_AXCFG_LSB +: 4];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) line_len <= 5'd0;
    else if (line_done) line_len <= 5'd0;
    else if (rx_wr && line_len < LINE_MAX[4:0]) begin
      line[line_len[3:0]] <= avs_writedata[7:0];
      line_len <= line_len + 5'd1;
    end
  end

  // homing order z, y, x, a
  always_comb begin
    cur_axis = 4'h0;
    if (home_mask[2]) cur_axis = 4'h4;
    else if (home_mask[1]) cur_axis = 4'h2;
    else if (home_mask[0]) cur_axis = AXIS_X;
    else if (home_mask[3]) cur_axis = AXIS_A;
    next_mask = home_mask & ~cur_axis;
  end

  // control state, program store, run
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= CPSR_IDLE;
      wr_ptr <= '0;
      rd_ptr <= '0;
      prog_valid <= 1'b0;
      prog_any <= 1'b0;
      resp <= '0;
      home_mask <= 4'h0;
      mode_3d <= 1'b0;
      ctrl <= 32'h0000_0000;
    end else begin
      if (avs_write && acc && avs_address == OFS_CTRL)
        ctrl <= avs_writedata;
      else if (ctrl[CTRL_ERASE]) ctrl[CTRL_ERASE] <= 1'b0;
      if (ctrl[CTRL_ERASE]) begin
        prog_valid <= 1'b0;
        prog_any <= 1'b0;
        wr_ptr <= '0;
      end
      case (state)
        CPSR_IDLE: begin
          if (line_done && is_erase) begin
            prog_valid <= 1'b0;
            prog_any <= 1'b0;
            wr_ptr <= '0;
            resp <= '{1'b1, RSP_ACK};
          end else if (line_done && is_save) begin
            if (!ctrl[CTRL_INIT] || ctrl[CTRL_MOVING])
              resp <= '{1'b1, RSP_ERR_BUSY};
            else if (prog_any)
              resp <= '{1'b1, RSP_ERR_STORED};
            else begin
              state <= CPSR_STORE;
              resp <= '{1'b1, RSP_ACK};
            end
          end else if (start_s[1] && !start_q && prog_valid) begin
            state <= CPSR_RUN;
            rd_ptr <= '0;
          end
        end
        CPSR_STORE: begin
          if (ctrl[CTRL_XFER_ERR] || (wr_ptr == '1 && line_done)) begin
            state <= CPSR_IDLE;
            prog_valid <= 1'b0;
            resp <= '{1'b1, RSP_ERR_GEN};
          end else if (line_done && is_end) begin
            state <= CPSR_IDLE;
            prog_valid <= 1'b1;
            resp <= '{1'b1, RSP_ACK};
          end else if (line_done && is_ref) begin
            if ((mask_val & ~axcfg) != 4'h0) begin
              state <= CPSR_IDLE;
              prog_valid <= 1'b0;
              resp <= '{1'b1, RSP_ERR_AXIS};
            end else begin
              mem[wr_ptr] <= {4'h0, mask_val};
              wr_ptr <= wr_ptr + 1'b1;
              prog_any <= 1'b1;
              resp <= '{1'b1, RSP_ACK};
            end
          end else if (line_done) begin
            state <= CPSR_IDLE;
            prog_valid <= 1'b0;
            prog_any <= 1'b1;
            resp <= '{1'b1, RSP_ERR_GEN};
          end
        end
        CPSR_RUN: begin
          if (rd_ptr == wr_ptr) state <= CPSR_IDLE;
          else begin
            home_mask <= mem[rd_ptr][3:0];
            rd_ptr <= rd_ptr + 1'b1;
            mode_3d <= 1'b0;
            state <= CPSR_HOME;
          end
        end
        CPSR_HOME: begin
          if (stop_s[1]) begin
            home_mask <= 4'h0;
            state <= CPSR_IDLE;
          end else if (home_mask == 4'h0) state <= CPSR_RUN;
          else if ((home_s2 & cur_axis) != 4'h0) home_mask <= next_mask;
        end
        default: state <= CPSR_IDLE;
      endcase
      if (avs_read && acc && avs_address == OFS_RESP) resp.valid <= 1'b0;
    end
  end

  // axis drive stays on until its home switch trips or stop asserts
  always_ff @(posedge ref_clk) begin
    if (!rst_n) home_drive <= 4'h0;
    else if (state == CPSR_HOME && !stop_s[1]) home_drive <= cur_axis;
    else home_drive <= 4'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) prog_running <= 1'b0;
    else prog_running <= (state == CPSR_RUN) || (state == CPSR_HOME);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !acc) begin
      if (avs_address == OFS_CTRL) avs_readdata <= ctrl;
      else if (avs_address == OFS_STATUS)
        avs_readdata <= {24'h0, home_mask, 1'b0, state == CPSR_STORE,
                         prog_any, prog_valid};
      else if (avs_address == OFS_RXDATA) avs_readdata <= 32'h0000_0000;
      else if (avs_address == OFS_RESP)
        avs_readdata <= {23'h0, resp.valid, resp.code};
      else avs_readdata <= UNMAPPED;
    end
  end
endmodule : cpsr_core
`default_nettype wire

// >>> core/cpsr_pkg.sv
// package for the cnc program store and reference interpreter
// assumes a 32-bit avalon-mm slave and a byte-wide serial receive stream
package cpsr_pkg;
  localparam logic [7:0] CH_AT   = 8'h40;
  localparam logic [7:0] CH_I    = 8'h69;
  localparam logic [7:0] CH_K    = 8'h6B;
  localparam logic [7:0] CH_SEVEN = 8'h37;
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_ENDF = 8'h39;
  localparam logic [7:0] RSP_ACK = 8'h30;
  localparam logic [7:0] RSP_ERR_GEN = 8'h31;
  localparam logic [7:0] RSP_ERR_AXIS = 8'h33;
  localparam logic [7:0] RSP_ERR_BUSY = 8'h35;
  localparam logic [7:0] RSP_ERR_STORED = 8'h34;
  localparam int PROG_DEPTH = 256;
  localparam int PROG_AW = 8;
  localparam int LINE_MAX = 16;
  localparam logic [3:0] AXIS_X = 4'h1;
  localparam logic [3:0] AXIS_A = 4'h8;
  localparam logic [3:0] AXIS_CNT_MAX = 4'h4;
  // register offsets (byte addresses)
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_RXDATA = 4'h8;
  localparam logic [3:0] OFS_RESP   = 4'hC;
  // ctrl fields
  localparam int CTRL_INIT = 0;
  localparam int CTRL_MOVING = 1;
  localparam int CTRL_ERASE = 2;
  localparam int CTRL_XFER_ERR = 3;
  localparam int CTRL_AXCFG_LSB = 4;
  localparam logic [31:0] UNMAPPED = 32'hDEAD_BEEF;
  typedef enum logic [2:0] {
    CPSR_IDLE  = 3'b000,
    CPSR_STORE = 3'b001,
    CPSR_RUN   = 3'b011,
    CPSR_HOME  = 3'b010,
    CPSR_FAIL  = 3'b110
  } cpsr_state_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } cpsr_resp_t;
endpackage : cpsr_pkg

// >>> verification/cpsr_axis_model.sv
// axis and home switch model facing home_drive
// assumes open_mask marks axes whose switch is not connected
`timescale 1ns/100ps
`default_nettype none
module cpsr_axis_model
  import cpsr_pkg::*;
#(parameter int DLY = 6)
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] home_drive,
  input  wire logic [3:0] open_mask,
  output logic [3:0]      home_sw
);
  logic [3:0] cnt [4];
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n || !home_drive[i]) cnt[i] <= 4'h0;
      else if (cnt[i] != 4'hF) cnt[i] <= cnt[i] + 4'h1;
      // open switch never closes, axis stays driven
      home_sw[i] <= rst_n && home_drive[i] && !open_mask[i] && cnt[i] >= DLY;
    end
  end
endmodule : cpsr_axis_model
`default_nettype wire

// >>> verification/cpsr_props.sv
// port checker for cpsr_core
// assumes bind to cpsr_core, single ref_clk domain
`timescale 1ns/100ps
`default_nettype none
module cpsr_props
  import cpsr_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        start_in,
  input wire logic        stop_in,
  input wire logic [3:0]  home_sw,
  input wire logic [3:0]  home_drive,
  input wire logic        mode_3d,
  input wire logic        prog_running
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic rq = avs_read || avs_write;
  chk_wait_answer: assert property ($rose(rq) |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  chk_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_unmapped_read: assert property (avs_read && !avs_waitrequest
    && avs_address == 4'h2 |-> avs_readdata == UNMAPPED)
    else $error("unmapped read value wrong");
  chk_one_axis: assert property ($onehot0(home_drive))
    else $error("more than one axis driven");
  chk_no_3d: assert property (!mode_3d)
    else $error("3d mode active");
  chk_x_after_y: assert property (home_drive == 4'h1 |=> home_drive[2:1] == 2'b00)
    else $error("y or z homed after x");
  chk_y_after_z: assert property (home_drive == 4'h2 |=> !home_drive[2])
    else $error("z homed after y");
  chk_keep_drive: assert property (home_drive != 4'h0 && (home_drive & home_sw) == 4'h0
    && !stop_in |=> home_drive != 4'h0)
    else $error("homing dropped without switch or stop");
  chk_stop_abort: assert property (stop_in && home_drive != 4'h0
    |-> ##[1:8] home_drive == 4'h0)
    else $error("stop did not abort homing");
  cover property ($rose(prog_running));
  cover property (home_drive == 4'h4 ##[1:200] home_drive == 4'h1);
  cover property (stop_in && home_drive == 4'h4);
endmodule : cpsr_props
bind cpsr_core cpsr_props u_cpsr_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .start_in(start_in), .stop_in(stop_in),
  .home_sw(home_sw), .home_drive(home_drive), .mode_3d(mode_3d),
  .prog_running(prog_running));
`default_nettype wire

// >>> verification/tb_cpsr_core.sv
// bench for cpsr_core over avalon-mm
// assumes cpsr_axis_model answers home_drive
`timescale 1ns/100ps
`default_nettype none
module tb_cpsr_core;
  import cpsr_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        start_in, stop_in, mode_3d, prog_running;
  logic [3:0]  avs_address, home_sw, home_drive, open_mask;
  logic [3:0]  last = 4'h0;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] trail = 16'h0000;
  int          err_total = 0;
  int          n_checks = 0;
  cpsr_core u_cpsr_core (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .start_in(start_in), .stop_in(stop_in),
    .home_sw(home_sw), .home_drive(home_drive), .mode_3d(mode_3d),
    .prog_running(prog_running));
  cpsr_axis_model u_cpsr_axis_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .home_drive(home_drive), .open_mask(open_mask), .home_sw(home_sw));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (home_drive != 4'h0 && home_drive != last) trail <= {trail[11:0], home_drive};
    last <= home_drive;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask : av
  task automatic expect_rd(input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask : expect_rd
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) av(1'b1, OFS_RXDATA, {24'h00_0000, s[i]});
    av(1'b1, OFS_RXDATA, {24'h00_0000, CH_CR});
    repeat (4) @(posedge ref_clk);
  endtask : send_line
  task automatic run_prog;
    start_in <= 1'b1;
    repeat (5) @(posedge ref_clk);
    start_in <= 1'b0;
  endtask : run_prog
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
  initial begin
    {rst_n, avs_read, avs_write, start_in, stop_in} = 5'b0_0000;
    {avs_address, open_mask, avs_writedata} = '0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    expect_rd(4'h2, UNMAPPED);
    send_line("@0i");
    expect_rd(OFS_RESP, 32'h0000_0135);
    av(1'b1, OFS_CTRL, 32'h0000_0073);
    send_line("@0i");
    expect_rd(OFS_RESP, 32'h0000_0135);
    av(1'b1, OFS_CTRL, 32'h0000_0071);
    send_line("@0i");
    expect_rd(OFS_RESP, 32'h0000_0130);
    expect_rd(OFS_STATUS, 32'h0000_0004);
    send_line("77");
    `CHK(home_drive, 4'h0)
    send_line("9");
    expect_rd(OFS_STATUS, 32'h0000_0003);
    send_line("@0i");
    expect_rd(OFS_RESP, 32'h0000_0134);
    run_prog();
    for (int n = 0; n < 50 && prog_running !== 1'b1; n++) @(posedge ref_clk);
    `CHK(prog_running, 1'b1)
    for (int n = 0; n < 500 && prog_running !== 1'b0; n++) @(posedge ref_clk);
    `CHK(trail[11:0], 12'h421)
    `CHK(mode_3d, 1'b0)
    send_line("@0k");
    expect_rd(OFS_STATUS, 32'h0000_0000);
    send_line("@0i");
    send_line("q");
    expect_rd(OFS_STATUS, 32'h0000_0002);
    run_prog();
    repeat (20) @(posedge ref_clk);
    `CHK(prog_running, 1'b0)
    send_line("@0k");
    send_line("@0i");
    send_line("78");
    expect_rd(OFS_RESP, 32'h0000_0133);
    expect_rd(OFS_STATUS, 32'h0000_0000);
    av(1'b1, OFS_CTRL, 32'h0000_00F1);
    send_line("@0i");
    send_line("78");
    send_line("74");
    send_line("9");
    open_mask <= 4'h4;
    run_prog();
    for (int n = 0; n < 50 && home_drive !== 4'h4; n++) @(posedge ref_clk);
    repeat (30) @(posedge ref_clk);
    `CHK(home_drive, 4'h4)
    stop_in <= 1'b1;
    for (int n = 0; n < 20 && home_drive !== 4'h0; n++) @(posedge ref_clk);
    stop_in <= 1'b0;
    `CHK(home_drive, 4'h0)
    stop_test();
  end
endmodule : tb_cpsr_core
`default_nettype wire
